/* File: core/sysrst_map.svh */
`ifndef SYSRST_MAP_SVH
`define SYSRST_MAP_SVH
// What this block does
// [R1] Bus clock is the clock generator output divided by two.
// [R2] Bus rate is reference or PLL clock divided by four.
// [R3] After power-on or low-voltage reset, hold clocks off for 4096 cycles.
// [R4] Drive the reset pin low during the whole startup timeout.
// [R5] Start the internal bus clocks when the startup timeout ends.
// [R6] Wait mode stops processor clocks; peripheral clocks keep running.
// [R7] Every reset source asserts internal reset; vector depends on monitor mode.
// [R8] Internal reset returns registers and modules to their reset state; a break/wait event under reset still sets the stop/wait flag.
// [R9] Internal resets clear the system counter; pin resets leave it.
// [R10] Each reset source sets its own cause bit.
// [R11] Reset pin held low halts all processing while low.
// [R12] Pin cause bit needs 67 low cycles outside power-on or low-voltage.
// [R13] During power-on or low-voltage reset, pin cause needs 4163 low cycles.
// [R14] Writing zero to the break stop/wait flag clears it.
// [R15] Internal resets drive the pin 32 cycles, then hold reset 32 more.
// [R16] Release processor 64 cycles after the 4096-cycle count ends.
// [R17] System counter is 13 bits, stepping on the reference falling edge.
// [R18] Software writes never change reset cause bits.

// Register indices; byte address is four times the index
`define IDX_BREAK_STATUS        16'hfe00
`define IDX_RESET_CAUSE_STATUS  16'hfe01
`define IDX_BREAK_FLAG_CONTROL  16'hfe03

`define BRK_STOP_WAIT_BIT       1
`define BRK_CLR_EN_BIT          7
`define CAUSE_POR_BIT           7
`define CAUSE_PIN_BIT           6
`define CAUSE_WDOG_BIT          5
`define CAUSE_OPCODE_BIT        4
`define CAUSE_ADDR_BIT          3
`define CAUSE_LVI_BIT           1

`define CAUSE_RESET_VAL         8'h80
`define BREAK_STATUS_RESET_VAL  8'h00
`define BREAK_CTRL_RESET_VAL    8'h00

`define POR_TIMEOUT_CYCLES      4096
`define POR_RELEASE_CYCLES      64
`define INT_DRIVE_CYCLES        32
`define INT_HOLD_CYCLES         32
`define PIN_MIN_CYCLES          67
`define PIN_MIN_POR_CYCLES      4163
`define SYS_COUNTER_W           13

`define VEC_NORMAL              16'hfffe
`define VEC_MONITOR             16'hfefe
`endif

/* File: core/sysrst_pkg.sv */
package sysrst_pkg;
  typedef enum logic [2:0] {
    ST_RUN,
    ST_POR,
    ST_DRIVE,
    ST_HOLD,
    ST_EXT
  } seq_state_t;
endpackage : sysrst_pkg

/* File: core/system_reset_clock_control.sv */
// Local design decision: the APB interface to the registers.
`timescale 1ns/1ps
`include "sysrst_map.svh"

module system_reset_clock_control #(
  parameter int unsigned POR_CYCLES     = `POR_TIMEOUT_CYCLES,
  parameter int unsigned PIN_POR_CYCLES = `PIN_MIN_POR_CYCLES,
  parameter int unsigned ADDR_W         = 18
) (
  input  wire logic                      pclk,
  input  wire logic                      presetn,
  input  wire logic                      psel,
  input  wire logic                      penable,
  input  wire logic                      pwrite,
  input  wire logic [ADDR_W-1:0]         paddr,
  input  wire logic [31:0]               pwdata,
  output logic      [31:0]               prdata,
  output logic                           pready,
  output logic                           pslverr,
  input  wire logic                      power_on_pulse,
  input  wire logic                      low_voltage_inhibit,
  input  wire logic                      watchdog_reset_flag,
  input  wire logic                      bad_opcode_flag,
  input  wire logic                      bad_fetch_address_flag,
  input  wire logic                      monitor_mode,
  input  wire logic                      wait_mode,
  input  wire logic                      break_wait_event,
  input  wire logic                      clock_gen_output,
  input  wire logic                      rst_pin_in,
  output logic                           rst_pin_out,
  output logic                           rst_pin_oe,
  output logic                           internal_reset_signal,
  output logic                           bus_clock,
  output logic                           cpu_clock,
  output logic                           periph_clock,
  output logic      [15:0]               reset_vector,
  output logic      [`SYS_COUNTER_W-1:0] sys_counter,
  output logic                           break_flag_clear_enable
);

  localparam int unsigned CNT_W = 13;

  initial begin
    if (POR_CYCLES < 2 || POR_CYCLES >= (1 << CNT_W))
      $error("POR_CYCLES out of range");
    if (PIN_POR_CYCLES < 2 || PIN_POR_CYCLES >= (1 << CNT_W))
      $error("PIN_POR_CYCLES out of range");
    if (ADDR_W < 18)
      $error("ADDR_W too narrow for register map");
  end

  localparam logic [CNT_W-1:0] POR_LAST     = CNT_W'(POR_CYCLES - 1);
  localparam logic [CNT_W-1:0] DRIVE_LAST   = CNT_W'(`INT_DRIVE_CYCLES - 1);
  localparam logic [CNT_W-1:0] HOLD_LAST    = CNT_W'(`INT_HOLD_CYCLES - 1);
  localparam logic [CNT_W-1:0] RELEASE_LAST = CNT_W'(`POR_RELEASE_CYCLES - 1);
  localparam logic [CNT_W-1:0] PIN_LAST     = CNT_W'(`PIN_MIN_CYCLES - 1);
  localparam logic [CNT_W-1:0] PIN_POR_LAST = CNT_W'(PIN_POR_CYCLES - 1);
  localparam logic [CNT_W-1:0] CNT_MAX      = '1;
  localparam logic [7:0]       BRK_RST      = `BREAK_STATUS_RESET_VAL;
  localparam logic [7:0]       CTRL_RST     = `BREAK_CTRL_RESET_VAL;

  sysrst_pkg::seq_state_t state;
  logic [CNT_W-1:0]       seq_cnt;
  logic [CNT_W-1:0]       pin_cnt;
  logic                   por_seq;
  logic                   int_src;
  logic                   slow_src;
  logic                   fast_src;
  logic                   pin_qualified;
  logic [7:0]             cause;
  logic                   stop_wait_flag;
  logic                   cgo_q;
  logic                   next_bus_clock;
  logic                   clocks_on;
  logic [15:0]            reg_idx;
  logic                   mapped;
  logic                   setup_phase;
  logic                   wr_access;
  logic [7:0]             read_byte;

  assign slow_src = power_on_pulse | low_voltage_inhibit;
  assign fast_src = watchdog_reset_flag | bad_opcode_flag | bad_fetch_address_flag;

  // Reset sequencer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state   <= sysrst_pkg::ST_POR;
      seq_cnt <= '0;
      por_seq <= 1'b1;
      int_src <= 1'b1;
    end else if (slow_src) begin
      // [R3] Restart startup count
      state   <= sysrst_pkg::ST_POR;
      seq_cnt <= '0;
      por_seq <= 1'b1;
      int_src <= 1'b1;
    end else begin
      unique case (state)
        sysrst_pkg::ST_POR: begin
          // [R3] Count startup timeout
          if (seq_cnt == POR_LAST) begin
            state   <= sysrst_pkg::ST_HOLD;
            seq_cnt <= '0;
          end else begin
            seq_cnt <= seq_cnt + 1'b1;
          end
        end
        sysrst_pkg::ST_DRIVE: begin
          // [R15] Pin drive phase
          if (seq_cnt == DRIVE_LAST) begin
            state   <= sysrst_pkg::ST_HOLD;
            seq_cnt <= '0;
          end else begin
            seq_cnt <= seq_cnt + 1'b1;
          end
        end
        sysrst_pkg::ST_HOLD: begin
          // [R16] Longer release after startup
          if (seq_cnt == (por_seq ? RELEASE_LAST : HOLD_LAST)) begin
            state   <= sysrst_pkg::ST_RUN;
            seq_cnt <= '0;
            por_seq <= 1'b0;
            int_src <= 1'b0;
          end else begin
            seq_cnt <= seq_cnt + 1'b1;
          end
        end
        sysrst_pkg::ST_EXT: begin
          // [R11] Halted until pin rises
          if (rst_pin_in) begin
            // Edge that sees the pin rise is the first hold cycle
            state   <= sysrst_pkg::ST_HOLD;
            seq_cnt <= CNT_W'(1);
          end
        end
        sysrst_pkg::ST_RUN: begin
          // [R7] Any source enters reset
          if (fast_src) begin
            state   <= sysrst_pkg::ST_DRIVE;
            seq_cnt <= '0;
            int_src <= 1'b1;
          end else if (!rst_pin_in) begin
            state   <= sysrst_pkg::ST_EXT;
            seq_cnt <= '0;
          end
        end
      endcase
    end
  end

  // [R4] Pin driven low in startup
  assign rst_pin_oe  = (state == sysrst_pkg::ST_POR) || (state == sysrst_pkg::ST_DRIVE);
  assign rst_pin_out = 1'b0;
  // [R7] Internal reset from every source
  assign internal_reset_signal = (state != sysrst_pkg::ST_RUN);

  // Counts how long the pin wire has been low, our own drive included
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_cnt <= '0;
    end else if (rst_pin_in) begin
      pin_cnt <= '0;
    end else if (pin_cnt != CNT_MAX) begin
      pin_cnt <= pin_cnt + 1'b1;
    end
  end

  // [R12] Longer threshold in startup
  // [R13] Pin must outlast the startup drive
  assign pin_qualified = !rst_pin_in && (pin_cnt == (por_seq ? PIN_POR_LAST : PIN_LAST));

  // [R18] Bus writes never reach this
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cause <= `CAUSE_RESET_VAL;
    end else if (power_on_pulse) begin
      // [R10] Power-on cause only
      cause <= `CAUSE_RESET_VAL;
    end else if (low_voltage_inhibit) begin
      cause <= 8'h00;
      cause[`CAUSE_LVI_BIT] <= 1'b1;
    end else if (state == sysrst_pkg::ST_RUN && fast_src) begin
      // [R10] One bit per source
      cause <= 8'h00;
      cause[`CAUSE_WDOG_BIT]   <= watchdog_reset_flag;
      cause[`CAUSE_OPCODE_BIT] <= bad_opcode_flag;
      cause[`CAUSE_ADDR_BIT]   <= bad_fetch_address_flag;
    end else if (state == sysrst_pkg::ST_RUN && !rst_pin_in) begin
      cause <= 8'h00;
    end else if (pin_qualified) begin
      cause[`CAUSE_PIN_BIT] <= 1'b1;
    end
  end

  // [R1] Toggle on each generator rising edge
  // [R2] Generator at half rate gives quarter
  assign clocks_on = (state != sysrst_pkg::ST_POR);
  always_comb begin
    if (!clocks_on) begin
      next_bus_clock = 1'b0;
    end else if (clock_gen_output && !cgo_q) begin
      next_bus_clock = !bus_clock;
    end else begin
      next_bus_clock = bus_clock;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cgo_q        <= 1'b0;
      bus_clock    <= 1'b0;
      cpu_clock    <= 1'b0;
      periph_clock <= 1'b0;
    end else begin
      cgo_q        <= clock_gen_output;
      // [R5] Clocks run once timeout ends
      bus_clock    <= next_bus_clock;
      periph_clock <= next_bus_clock;
      // [R6] Processor clock stops in wait
      cpu_clock    <= next_bus_clock && !wait_mode && (state != sysrst_pkg::ST_EXT);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      reset_vector <= `VEC_NORMAL;
    end else begin
      // [R7] Monitor mode vector pair
      reset_vector <= monitor_mode ? `VEC_MONITOR : `VEC_NORMAL;
    end
  end

  // [R17] Falling-edge system counter
  always_ff @(negedge pclk or negedge presetn) begin
    if (!presetn) begin
      sys_counter <= '0;
    end else if (int_src && state != sysrst_pkg::ST_RUN) begin
      // [R9] Only internal resets clear
      sys_counter <= '0;
    end else begin
      sys_counter <= sys_counter + 1'b1;
    end
  end

  // Register bus: data captured in setup, so one access cycle always ends it
  assign reg_idx     = paddr[17:2];
  assign setup_phase = psel && !penable;
  assign wr_access   = psel && penable && pwrite;
  assign pready      = psel && penable;
  assign mapped      = (reg_idx == `IDX_BREAK_STATUS) ||
                       (reg_idx == `IDX_RESET_CAUSE_STATUS) ||
                       (reg_idx == `IDX_BREAK_FLAG_CONTROL);

  always_comb begin
    read_byte = 8'h00;
    if (reg_idx == `IDX_BREAK_STATUS) begin
      read_byte[`BRK_STOP_WAIT_BIT] = stop_wait_flag;
    end else if (reg_idx == `IDX_RESET_CAUSE_STATUS) begin
      read_byte = cause;
    end else if (reg_idx == `IDX_BREAK_FLAG_CONTROL) begin
      read_byte[`BRK_CLR_EN_BIT] = break_flag_clear_enable;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (setup_phase) begin
      prdata  <= {24'h00_0000, read_byte};
      pslverr <= !mapped;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stop_wait_flag <= BRK_RST[`BRK_STOP_WAIT_BIT];
    end else if (break_wait_event) begin
      // Set wins over any clear in the same cycle
      stop_wait_flag <= 1'b1;
    end else if (internal_reset_signal) begin
      // [R8] Defaults under reset
      stop_wait_flag <= 1'b0;
    end else if (wr_access && reg_idx == `IDX_BREAK_STATUS
                 && !pwdata[`BRK_STOP_WAIT_BIT]) begin
      // [R14] Zero write clears
      stop_wait_flag <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      break_flag_clear_enable <= CTRL_RST[`BRK_CLR_EN_BIT];
    end else if (internal_reset_signal) begin
      // [R8] Defaults under reset
      break_flag_clear_enable <= 1'b0;
    end else if (wr_access && reg_idx == `IDX_BREAK_FLAG_CONTROL) begin
      break_flag_clear_enable <= pwdata[`BRK_CLR_EN_BIT];
    end
  end

endmodule : system_reset_clock_control

/* File: tb/sysrst_assertions.sv */
`timescale 1ns/1ps
`include "sysrst_map.svh"

module sysrst_assertions #(
  parameter int unsigned POR_CYCLES = 16
) (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        power_on_pulse,
  input wire logic        low_voltage_inhibit,
  input wire logic        watchdog_reset_flag,
  input wire logic        bad_opcode_flag,
  input wire logic        bad_fetch_address_flag,
  input wire logic        monitor_mode,
  input wire logic        wait_mode,
  input wire logic        clock_gen_output,
  input wire logic        rst_pin_in,
  input wire logic        rst_pin_oe,
  input wire logic        internal_reset_signal,
  input wire logic        bus_clock,
  input wire logic        cpu_clock,
  input wire logic        periph_clock,
  input wire logic [15:0] reset_vector
);
  logic [15:0] oe_cnt;
  logic [15:0] hold_cnt;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // Spans are counted rather than unrolled; counts are long
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      oe_cnt <= '0;
    else
      oe_cnt <= rst_pin_oe ? oe_cnt + 16'h0001 : 16'h0000;
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      hold_cnt <= '0;
    else if (rst_pin_oe || !rst_pin_in)
      hold_cnt <= '0;
    else if (internal_reset_signal)
      hold_cnt <= hold_cnt + 16'h0001;
  end

  a_oe_span: assert property ($fell(rst_pin_oe) |-> (oe_cnt == 16'h0020) || (oe_cnt == POR_CYCLES))
    else $error("reset pin drive span wrong");
  a_hold_span: assert property ($fell(internal_reset_signal) |-> hold_cnt inside {16'h0020, 16'h0040})
    else $error("reset hold span wrong");
  a_drive_in_reset: assert property (rst_pin_oe |-> internal_reset_signal)
    else $error("pin driven outside reset");
  a_startup_clocks_off: assert property ((power_on_pulse || low_voltage_inhibit) |-> ##2 (rst_pin_oe && !bus_clock && !cpu_clock))
    else $error("clocks running during startup");
  a_source_taken: assert property ((!internal_reset_signal && rst_pin_in && (watchdog_reset_flag || bad_opcode_flag || bad_fetch_address_flag)) |=> (rst_pin_oe && internal_reset_signal) [*8])
    else $error("internal source not taken");
  a_vector_sel: assert property (1'b1 |=> reset_vector == ($past(monitor_mode) ? `VEC_MONITOR : `VEC_NORMAL))
    else $error("reset vector wrong");
  a_wait_stops_cpu: assert property (wait_mode |=> !cpu_clock)
    else $error("cpu clock runs in wait");
  a_bus_divide: assert property ((!internal_reset_signal && $rose(clock_gen_output)) |-> ##[1:2] $changed(bus_clock))
    else $error("bus clock not following generator");
  a_periph_in_wait: assert property ((wait_mode && !internal_reset_signal && $rose(clock_gen_output)) |-> ##[1:2] $changed(periph_clock))
    else $error("peripheral clock stopped in wait");
endmodule : sysrst_assertions

bind system_reset_clock_control sysrst_assertions #(.POR_CYCLES(POR_CYCLES)) chk (.*);

/* File: tb/pin_partner.sv */
`timescale 1ns/1ps

module pin_partner (
  input  wire logic pclk,
  input  wire logic rst_pin_out,
  input  wire logic rst_pin_oe,
  input  wire logic hold_low,
  output logic      rst_pin_in,
  output logic      clock_gen_output
);
  initial clock_gen_output = 1'b0;
  // Generator output runs free
  always @(posedge pclk) begin
    clock_gen_output <= ~clock_gen_output;
  end
  assign rst_pin_in = ~hold_low & (rst_pin_oe ? rst_pin_out : 1'b1);
endmodule : pin_partner

/* File: tb/test_system_reset_clock_control.sv */
`timescale 1ns/1ps
`include "sysrst_map.svh"

module test_system_reset_clock_control;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, hold_low;
  logic        power_on_pulse, low_voltage_inhibit, watchdog_reset_flag;
  logic        bad_opcode_flag, bad_fetch_address_flag, monitor_mode, wait_mode;
  logic        break_wait_event, clock_gen_output, rst_pin_in, rst_pin_out, rst_pin_oe;
  logic        internal_reset_signal, bus_clock, cpu_clock, periph_clock;
  logic        break_flag_clear_enable;
  logic [17:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [15:0] reset_vector;
  logic [12:0] sys_counter, cnt_before;
  logic [4:0]  src;
  logic [7:0]  cause_exp [5] = '{8'h80, 8'h02, 8'h20, 8'h10, 8'h08};
  logic [32:0] expq [$];
  int          fails, checks_done, n, len;

  assign {power_on_pulse, low_voltage_inhibit, watchdog_reset_flag} = src[4:2];
  assign {bad_opcode_flag, bad_fetch_address_flag} = src[1:0];

  system_reset_clock_control #(.POR_CYCLES(16), .PIN_POR_CYCLES(83)) dut (.*);
  pin_partner far_end (.*);

  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  initial begin
    #200us;
    fails++;
    complete_run();
  end

  task automatic check(input logic [32:0] seen, input logic [32:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  always @(posedge pclk) begin
    if (psel && penable && pready && !pwrite) check({pslverr, prdata}, expq.pop_front());
  end

  task automatic apb(input logic wr, input logic [15:0] idx, input logic [31:0] d,
                     input logic [32:0] exp);
    @(posedge pclk);
    if (!wr) expq.push_back(exp);
    {monitor_mode, wait_mode} <= 2'($urandom);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {idx, 2'b00};
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic rd(input logic [15:0] idx, input logic [7:0] v);
    apb(1'b0, idx, 32'h0, {25'h0, v});
  endtask : rd

  task automatic wait_run;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (internal_reset_signal !== 1'b0 && n < 3000);
    if (internal_reset_signal !== 1'b0) fails++;
  endtask : wait_run

  task automatic complete_run;
    $display("checks %0d fails %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : complete_run

  initial begin
    void'($urandom(32'h7c94b73d));
    {presetn, psel, penable, pwrite, monitor_mode, wait_mode, break_wait_event, hold_low} = '0;
    paddr = '0;
    pwdata = '0;
    src = '0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    wait_run();
    rd(`IDX_RESET_CAUSE_STATUS, 8'h80);
    apb(1'b1, `IDX_RESET_CAUSE_STATUS, $urandom, 33'h0);
    rd(`IDX_RESET_CAUSE_STATUS, 8'h80);
    apb(1'b0, 16'hfe02, 32'h0, {1'b1, 32'h0});
    $display("registers done");
    @(posedge pclk);
    break_wait_event <= 1'b1;
    @(posedge pclk);
    break_wait_event <= 1'b0;
    rd(`IDX_BREAK_STATUS, 8'h02);
    apb(1'b1, `IDX_BREAK_STATUS, 32'h0, 33'h0);
    rd(`IDX_BREAK_STATUS, 8'h00);
    apb(1'b1, `IDX_BREAK_FLAG_CONTROL, 32'h80, 33'h0);
    @(posedge pclk);
    check(break_flag_clear_enable, 1'b1);
    $display("break done");
    for (int k = 0; k < 5; k++) begin
      @(posedge pclk);
      src <= 5'b10000 >> k;
      @(posedge pclk);
      src <= 5'h00;
      wait_run();
      if (k > 1) check(sys_counter < 13'h0008, 1'b1);
      rd(`IDX_RESET_CAUSE_STATUS, cause_exp[k]);
      rd(`IDX_BREAK_FLAG_CONTROL, 8'h00);
    end
    $display("sources done");
    for (int k = 0; k < 2; k++) begin
      @(posedge pclk);
      len = k ? 80 : 30;
      cnt_before = sys_counter;
      hold_low <= 1'b1;
      repeat (len) @(posedge pclk);
      check(cpu_clock, 1'b0);
      hold_low <= 1'b0;
      wait_run();
      check(sys_counter, cnt_before + 13'(len + n));
      rd(`IDX_RESET_CAUSE_STATUS, k ? 8'h40 : 8'h00);
    end
    $display("pin done");
    complete_run();
  end
endmodule : test_system_reset_clock_control
